//--- stg_desc_decode.sv
// Field extraction from one 64-bit segment or gate descriptor.
// Pure combinational; the caller registers whatever it keeps.
module stg_desc_decode
   import stg_pkg::*;
(
   // Raw descriptor
   input wire logic [63:0] desc,
   // Segment fields
   output logic [31:0] base,
   output logic [1:0] dpl,
   output logic present,
   output logic is_code,
   output logic is_data,
   // Gate fields
   output logic is_call_gate,
   output logic [15:0] gate_sel,
   output logic [31:0] gate_off
);
   logic sys;
   assign sys = ~desc[DESC_S_BIT];
   assign base = {desc[DESC_BASE_HI_LSB +: 8], desc[DESC_BASE_LO_LSB +: 24]};
   assign dpl = desc[DESC_DPL_LSB +: 2];
   assign present = desc[DESC_P_BIT];
   assign is_code = ~sys & desc[DESC_TYPE_LSB + TYPE_CODE_BIT];
   assign is_data = ~sys & ~desc[DESC_TYPE_LSB + TYPE_CODE_BIT];
   assign is_call_gate = sys & (desc[DESC_TYPE_LSB +: 4] == TYPE_CALL_GATE);
   assign gate_sel = desc[GATE_SEL_LSB +: 16];
   assign gate_off = {desc[GATE_OFF_HI_LSB +: 16], desc[15:0]};
endmodule // stg_desc_decode

//--- stg_mem_model.sv
// Behavioural descriptor memory on the read side of stg_unit.
// Assumes the bench loads entries with put and sets latency and error per request.
module stg_mem_model (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // Read port
   input wire logic mem_rd_req,
   input wire logic [31:0] mem_rd_addr,
   output logic mem_rd_ack,
   output logic [63:0] mem_rd_data,
   output logic mem_rd_err,
   // Bench controls
   input wire logic [1:0] lat,
   input wire logic fail
);
   logic [63:0] mem [logic [31:0]];
   logic [1:0] cnt_r;
   logic [63:0] last_r;
   logic [31:0] last_addr_r;

   task automatic put(input logic [31:0] a, input logic [63:0] d);
      mem[a] = d;
   endtask

   // Zero-wait ack allowed in the first request cycle
   assign mem_rd_ack = mem_rd_req && cnt_r == lat;
   assign mem_rd_err = mem_rd_ack ? fail : ~fail;

   // Inverse of last word off ack, so stale data never looks valid
   always_comb begin
      mem_rd_data = ~last_r;
      if (mem_rd_ack && mem.exists(mem_rd_addr))
         mem_rd_data = mem[mem_rd_addr];
   end

   always_ff @(posedge ref_clk) begin
      cnt_r <= (!resetn || !mem_rd_req || mem_rd_ack) ? 2'h0 : cnt_r + 2'h1;
      if (mem_rd_ack) begin
         last_r <= mem_rd_data;
         last_addr_r <= mem_rd_addr;
      end
   end
endmodule // stg_mem_model

//--- stg_pkg.sv
// Constants and types for the segment translate and gate check unit.
// Assumes 64-bit descriptors and task state entries read over a simple memory port.
package stg_pkg;
   // Selector layout
   localparam int SEL_RPL_LSB = 0;
   localparam int SEL_TI_BIT = 2;
   localparam int SEL_IDX_LSB = 3;
   localparam logic [15:0] SEL_NULL_MASK = 16'hFFFC;
   localparam logic [15:0] ERR_SEL_MASK = 16'hFFFC;
   localparam logic [15:0] ERR_CODE_ZERO = 16'h0000;
   // Descriptor layout
   localparam int DESC_BASE_LO_LSB = 16;
   localparam int DESC_BASE_HI_LSB = 56;
   localparam int DESC_TYPE_LSB = 40;
   localparam int DESC_S_BIT = 44;
   localparam int DESC_DPL_LSB = 45;
   localparam int DESC_P_BIT = 47;
   localparam int GATE_SEL_LSB = 16;
   localparam int GATE_OFF_HI_LSB = 48;
   localparam logic [3:0] TYPE_CALL_GATE = 4'hC;
   localparam int TYPE_CODE_BIT = 3;
   // Task state record: one 64-bit entry per level, stack pointer low, selector above
   localparam logic [31:0] TSS_STACK_OFS = 32'h0000_0008;
   localparam int TSS_SS_LSB = 32;
   // Exception vectors
   localparam logic [7:0] VEC_DIVIDE = 8'h00;
   localparam logic [7:0] VEC_PROT = 8'h0D;

   typedef enum logic [1:0] {
      STG_DATA = 2'h0,
      STG_STACK = 2'h1,
      STG_GATE = 2'h2,
      STG_DIV = 2'h3
   } stg_kind_t;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_SEG = 4'b0010,
      ST_TGT = 4'b0100,
      ST_STK = 4'b1000
   } stg_state_t;
endpackage

//--- stg_unit.sv
// Segment translation and call-gate privilege checking for the execution core.
// Assumes the core, table base inputs and descriptor memory share ref_clk.
//
// Overview of operation
// - Every protected access resolves through a global or local table descriptor.
// - Selector gives index, table-select bit and requested level; bit picks table.
// - Linear address is descriptor base plus supplied offset.
// - Code, data or stack access only if reachable from current level.
// - Global table base and local table base come from dedicated inputs.
// - Call gate reaches only code at equal or more privileged level.
// - Gate check compares current level with gate and target levels.
// - On pass, target selector and entry offset come from the gate.
// - Privilege change through gate loads new stack from task state record.
// - Faults without an accurate error code report code zero.
// - Integer divide by zero raises an exception.
// - Offsets are byte addresses, whatever the access width.
module stg_unit
   import stg_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // Request from the core
   input wire logic req_valid,
   output logic req_ready,
   input wire stg_pkg::stg_kind_t req_kind,
   input wire logic [15:0] req_sel,
   input wire logic [31:0] req_offset,
   input wire logic [31:0] req_divisor,
   input wire logic [1:0] current_priv_level,
   // Table and task state bases
   input wire logic [31:0] global_table_base_reg,
   input wire logic [31:0] local_table_base_reg,
   input wire logic [31:0] task_state_record,
   // Descriptor memory
   output logic mem_rd_req,
   output logic [31:0] mem_rd_addr,
   input wire logic mem_rd_ack,
   input wire logic [63:0] mem_rd_data,
   input wire logic mem_rd_err,
   // Response
   output logic rsp_valid,
   output logic rsp_fault,
   output logic [7:0] rsp_vector,
   output logic [15:0] rsp_err_code,
   output logic [31:0] rsp_linear,
   output logic [15:0] rsp_new_cs,
   output logic [31:0] rsp_new_ip,
   output logic [15:0] rsp_new_ss,
   output logic [31:0] rsp_new_sp,
   output logic rsp_stack_switch
);
   import stg_pkg::*;

   stg_state_t state_r, state_nxt;
   stg_kind_t kind_r, kind_nxt;
   logic [15:0] sel_r, sel_nxt;
   logic [31:0] off_r, off_nxt;
   logic [1:0] cpl_r, cpl_nxt;
   logic [15:0] gsel_r, gsel_nxt;
   logic [31:0] goff_r, goff_nxt;
   logic [1:0] tdpl_r, tdpl_nxt;
   logic req_ready_nxt, mem_rd_req_nxt, rsp_valid_nxt, rsp_fault_nxt, rsp_sw_nxt;
   logic [31:0] mem_rd_addr_nxt, rsp_linear_nxt, rsp_ip_nxt, rsp_sp_nxt;
   logic [7:0] rsp_vector_nxt;
   logic [15:0] rsp_err_nxt, rsp_cs_nxt, rsp_ss_nxt;
   logic saw_read_r;

   logic [31:0] d_base, d_goff;
   logic [1:0] d_dpl, eff_pl;
   logic d_p, d_code, d_data, d_gate;
   logic [15:0] d_gsel;
   logic take, got, seg_ok, gate_ok, tgt_ok;

   stg_desc_decode u_dec (
      .desc(mem_rd_data),
      .base(d_base),
      .dpl(d_dpl),
      .present(d_p),
      .is_code(d_code),
      .is_data(d_data),
      .is_call_gate(d_gate),
      .gate_sel(d_gsel),
      .gate_off(d_goff)
   );

   // Descriptor address: selected table base plus eight bytes per index
   function automatic logic [31:0] tbl_addr(input logic [15:0] s, input logic [31:0] gb, input logic [31:0] lb);
      return (s[SEL_TI_BIT] ? lb : gb) + {16'h0000, s[15:SEL_IDX_LSB], 3'h0};
   endfunction

   assign take = req_valid & req_ready;
   assign got = mem_rd_req & mem_rd_ack;
   // Weaker of current level and requested level governs data access
   assign eff_pl = (cpl_r > sel_r[SEL_RPL_LSB +: 2]) ? cpl_r : sel_r[SEL_RPL_LSB +: 2];
   // Stack needs a data segment at the current level; data access takes data or code at equal or lower privilege
   assign seg_ok = d_p & ((kind_r == STG_DATA) ? (d_data | d_code) & (d_dpl >= eff_pl)
                                               : d_data & (d_dpl == cpl_r));
   assign gate_ok = d_p & d_gate & (d_dpl >= eff_pl);
   assign tgt_ok = d_p & d_code & (d_dpl <= cpl_r);

   always_comb begin
      state_nxt = state_r;
      kind_nxt = kind_r;
      sel_nxt = sel_r;
      off_nxt = off_r;
      cpl_nxt = cpl_r;
      gsel_nxt = gsel_r;
      goff_nxt = goff_r;
      tdpl_nxt = tdpl_r;
      req_ready_nxt = req_ready;
      mem_rd_req_nxt = mem_rd_req;
      mem_rd_addr_nxt = mem_rd_addr;
      rsp_valid_nxt = 1'b0;
      rsp_fault_nxt = rsp_fault;
      rsp_vector_nxt = rsp_vector;
      rsp_err_nxt = rsp_err_code;
      rsp_linear_nxt = rsp_linear;
      rsp_cs_nxt = rsp_new_cs;
      rsp_ip_nxt = rsp_new_ip;
      rsp_ss_nxt = rsp_new_ss;
      rsp_sp_nxt = rsp_new_sp;
      rsp_sw_nxt = rsp_stack_switch;
      if (rsp_valid) begin
         rsp_fault_nxt = 1'b0;
         rsp_linear_nxt = '0;
         rsp_sw_nxt = 1'b0;
      end
      unique case (state_r)
         ST_IDLE: begin
            if (take) begin
               kind_nxt = req_kind;
               sel_nxt = req_sel;
               off_nxt = req_offset;
               cpl_nxt = current_priv_level;
               if (req_kind == STG_DIV) begin
                  rsp_valid_nxt = 1'b1;
                  rsp_fault_nxt = (req_divisor == 32'h0000_0000);
                  rsp_vector_nxt = VEC_DIVIDE;
                  rsp_err_nxt = ERR_CODE_ZERO;
               end else if ((req_sel & SEL_NULL_MASK) == 16'h0000) begin
                  // Null selector never reaches a table
                  rsp_valid_nxt = 1'b1;
                  rsp_fault_nxt = 1'b1;
                  rsp_vector_nxt = VEC_PROT;
                  rsp_err_nxt = ERR_CODE_ZERO;
               end else begin
                  req_ready_nxt = 1'b0;
                  mem_rd_req_nxt = 1'b1;
                  mem_rd_addr_nxt = tbl_addr(req_sel, global_table_base_reg, local_table_base_reg);
                  state_nxt = ST_SEG;
               end
            end
         end
         ST_SEG, ST_TGT, ST_STK: begin
            if (got) begin
               mem_rd_req_nxt = 1'b0;
               state_nxt = ST_IDLE;
               req_ready_nxt = 1'b1;
               rsp_valid_nxt = 1'b1;
               rsp_fault_nxt = 1'b1;
               rsp_vector_nxt = VEC_PROT;
               rsp_err_nxt = sel_r & ERR_SEL_MASK;
               if (mem_rd_err) begin
                  rsp_err_nxt = ERR_CODE_ZERO;
               end else if (state_r == ST_SEG && kind_r != STG_GATE) begin
                  if (seg_ok) begin
                     rsp_fault_nxt = 1'b0;
                     rsp_err_nxt = ERR_CODE_ZERO;
                     rsp_linear_nxt = d_base + off_r;
                  end
               end else if (state_r == ST_SEG) begin
                  if (gate_ok) begin
                     // Target comes from the gate, not from the request
                     gsel_nxt = d_gsel;
                     goff_nxt = d_goff;
                     sel_nxt = d_gsel;
                     rsp_valid_nxt = 1'b0;
                     rsp_fault_nxt = 1'b0;
                     req_ready_nxt = 1'b0;
                     if ((d_gsel & SEL_NULL_MASK) == 16'h0000) begin
                        rsp_valid_nxt = 1'b1;
                        rsp_fault_nxt = 1'b1;
                        rsp_err_nxt = ERR_CODE_ZERO;
                        req_ready_nxt = 1'b1;
                     end else begin
                        mem_rd_req_nxt = 1'b1;
                        mem_rd_addr_nxt = tbl_addr(d_gsel, global_table_base_reg, local_table_base_reg);
                        state_nxt = ST_TGT;
                     end
                  end
               end else if (state_r == ST_TGT) begin
                  if (tgt_ok) begin
                     rsp_cs_nxt = {gsel_r[15:2], d_dpl};
                     rsp_ip_nxt = goff_r;
                     tdpl_nxt = d_dpl;
                     if (d_dpl < cpl_r) begin
                        rsp_valid_nxt = 1'b0;
                        rsp_fault_nxt = 1'b0;
                        req_ready_nxt = 1'b0;
                        mem_rd_req_nxt = 1'b1;
                        mem_rd_addr_nxt = task_state_record + TSS_STACK_OFS + {27'h0, d_dpl, 3'h0};
                        state_nxt = ST_STK;
                     end else begin
                        rsp_fault_nxt = 1'b0;
                        rsp_err_nxt = ERR_CODE_ZERO;
                     end
                  end
               end else begin
                  rsp_fault_nxt = 1'b0;
                  rsp_err_nxt = ERR_CODE_ZERO;
                  rsp_ss_nxt = mem_rd_data[TSS_SS_LSB +: 16];
                  rsp_sp_nxt = mem_rd_data[31:0];
                  rsp_sw_nxt = 1'b1;
               end
               if (!rsp_fault_nxt) begin
                  rsp_vector_nxt = VEC_PROT;
               end
            end
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         state_r <= ST_IDLE;
         kind_r <= STG_DATA;
         sel_r <= '0;
         off_r <= '0;
         cpl_r <= '0;
         gsel_r <= '0;
         goff_r <= '0;
         tdpl_r <= '0;
         req_ready <= 1'b1;
         mem_rd_req <= 1'b0;
         mem_rd_addr <= '0;
         rsp_valid <= 1'b0;
         rsp_fault <= 1'b0;
         rsp_vector <= VEC_PROT;
         rsp_err_code <= ERR_CODE_ZERO;
         rsp_linear <= '0;
         rsp_new_cs <= '0;
         rsp_new_ip <= '0;
         rsp_new_ss <= '0;
         rsp_new_sp <= '0;
         rsp_stack_switch <= 1'b0;
         saw_read_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         kind_r <= kind_nxt;
         sel_r <= sel_nxt;
         off_r <= off_nxt;
         cpl_r <= cpl_nxt;
         gsel_r <= gsel_nxt;
         goff_r <= goff_nxt;
         tdpl_r <= tdpl_nxt;
         req_ready <= req_ready_nxt;
         mem_rd_req <= mem_rd_req_nxt;
         mem_rd_addr <= mem_rd_addr_nxt;
         rsp_valid <= rsp_valid_nxt;
         rsp_fault <= rsp_fault_nxt;
         rsp_vector <= rsp_vector_nxt;
         rsp_err_code <= rsp_err_nxt;
         rsp_linear <= rsp_linear_nxt;
         rsp_new_cs <= rsp_cs_nxt;
         rsp_new_ip <= rsp_ip_nxt;
         rsp_new_ss <= rsp_ss_nxt;
         rsp_new_sp <= rsp_sp_nxt;
         rsp_stack_switch <= rsp_sw_nxt;
         saw_read_r <= take ? 1'b0 : (saw_read_r | got);
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   sequence s_take_div;
      take && req_kind == STG_DIV;
   endsequence
   sequence s_take_table;
      take && req_kind != STG_DIV && (req_sel & SEL_NULL_MASK) != 16'h0000;
   endsequence
   sequence s_seg_pass;
      state_r == ST_SEG && got && !mem_rd_err && kind_r != STG_GATE && seg_ok;
   endsequence

   a_div_zero_fault: assert property (s_take_div and (req_divisor == 32'h0) |=>
      rsp_valid && rsp_fault && rsp_vector == VEC_DIVIDE) else $error("divide by zero not raised");
   a_div_ok_pass: assert property (s_take_div and (req_divisor != 32'h0) |=> rsp_valid && !rsp_fault)
      else $error("nonzero divisor faulted");
   a_null_code_zero: assert property (take && req_kind != STG_DIV && (req_sel & SEL_NULL_MASK) == 16'h0 |=>
      rsp_valid && rsp_fault && rsp_err_code == ERR_CODE_ZERO) else $error("null selector code wrong");
   a_rderr_code_zero: assert property (got && mem_rd_err |=> rsp_valid && rsp_fault && rsp_err_code == 16'h0)
      else $error("read error code not zero");
   a_table_pick: assert property (s_take_table |=> mem_rd_req && mem_rd_addr ==
      ($past(req_sel[SEL_TI_BIT]) ? $past(local_table_base_reg) : $past(global_table_base_reg))
      + {16'h0, $past(req_sel[15:SEL_IDX_LSB]), 3'h0}) else $error("wrong table address");
   a_linear_sum: assert property (s_seg_pass |=> rsp_valid && !rsp_fault && rsp_linear == $past(d_base) + off_r)
      else $error("linear address wrong");
   a_tables_only: assert property (rsp_valid && !rsp_fault && kind_r != STG_DIV |-> saw_read_r)
      else $error("access passed without descriptor");
   a_gate_priv: assert property (rsp_valid && !rsp_fault && kind_r == STG_GATE |-> tdpl_r <= cpl_r)
      else $error("gate reached less privileged code");
   a_stack_load: assert property (state_r == ST_STK && got && !mem_rd_err |=> rsp_valid && rsp_stack_switch
      && rsp_new_ss == $past(mem_rd_data[TSS_SS_LSB +: 16])) else $error("stack switch wrong");
   a_fault_no_addr: assert property (rsp_valid && rsp_fault |-> rsp_linear == 32'h0 && !rsp_stack_switch)
      else $error("faulted access produced address");
endmodule // stg_unit

//--- stg_unit_bench.sv
// Self-checking bench for stg_unit, random and corner-case requests.
// Assumes stg_pkg and stg_mem_model are compiled first.
module stg_unit_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import stg_pkg::*;
   localparam logic [31:0] GBASE = 32'h0001_0000;
   localparam logic [31:0] LBASE = 32'h0002_0000;
   localparam logic [31:0] TBASE = 32'h0003_0000;
   logic ref_clk, resetn, req_valid, req_ready, mem_rd_req, mem_rd_ack, mem_rd_err, fail;
   logic rsp_valid, rsp_fault, rsp_stack_switch;
   stg_kind_t req_kind, k;
   logic [15:0] req_sel, rsp_err_code, rsp_new_cs, rsp_new_ss, s;
   logic [31:0] req_offset, req_divisor, mem_rd_addr, rsp_linear, rsp_new_ip, rsp_new_sp, r, b, o;
   logic [31:0] lfsr_r = 32'h0001_15CF;
   logic [1:0] current_priv_level, lat, lv;
   logic [63:0] mem_rd_data;
   logic [7:0] rsp_vector;
   int error_cnt = 0;
   int total_checks = 0;
   int i;

   stg_unit stg_unit_i (.ref_clk, .resetn, .req_valid, .req_ready, .req_kind, .req_sel, .req_offset,
      .req_divisor, .current_priv_level, .global_table_base_reg(GBASE), .local_table_base_reg(LBASE),
      .task_state_record(TBASE), .mem_rd_req, .mem_rd_addr, .mem_rd_ack, .mem_rd_data, .mem_rd_err,
      .rsp_valid, .rsp_fault, .rsp_vector, .rsp_err_code, .rsp_linear, .rsp_new_cs, .rsp_new_ip,
      .rsp_new_ss, .rsp_new_sp, .rsp_stack_switch);
   stg_mem_model stg_mem_model_i (.ref_clk, .resetn, .mem_rd_req, .mem_rd_addr, .mem_rd_ack,
      .mem_rd_data, .mem_rd_err, .lat, .fail);

   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   function automatic logic [31:0] rnd();
      lfsr_r = {lfsr_r[30:0], lfsr_r[31] ^ lfsr_r[21] ^ lfsr_r[1] ^ lfsr_r[0]};
      return lfsr_r;
   endfunction
   function automatic logic [63:0] seg(input logic [31:0] sb, input logic [1:0] dpl, input logic code);
      return {sb[31:24], 8'h00, 1'b1, dpl, 1'b1, code ? 4'hA : 4'h2, sb[23:0], 16'hFFFF};
   endfunction
   function automatic logic [63:0] gate(input logic [15:0] gs, input logic [31:0] go, input logic [1:0] dpl);
      return {go[31:16], 1'b1, dpl, 1'b0, 4'hC, 8'h00, gs, go[15:0]};
   endfunction
   function automatic logic [31:0] slot(input logic [15:0] ss);
      return (ss[2] ? LBASE : GBASE) + 32'({ss[15:3], 3'h0});
   endfunction

   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      $display("checks=%0d errors=%0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic run(input stg_kind_t rk, input logic [15:0] rs, input logic [31:0] ro, dv,
         input logic [1:0] rl, input logic f, input logic [7:0] v, input logic [15:0] e, input logic [31:0] lin);
      logic [31:0] x;
      int n;
      x = rnd();
      lat = x[1:0];
      req_valid = 1'b1;
      req_kind = rk;
      req_sel = rs;
      req_offset = ro;
      req_divisor = dv;
      current_priv_level = rl;
      @(posedge ref_clk);
      #1;
      // Scramble released lines so late sampling shows up
      req_valid = 1'b0;
      req_sel = x[31:16];
      req_offset = ~ro;
      current_priv_level = x[3:2];
      for (n = 0; n < 40 && rsp_valid !== 1'b1; n++) begin
         @(posedge ref_clk);
         #1;
      end
      chk(rsp_valid, 1'b1);
      chk(rsp_fault, f);
      chk(rsp_err_code, e);
      if (f)
         chk(rsp_vector, v);
      if (f || rk == STG_DATA || rk == STG_STACK)
         chk(rsp_linear, lin);
   endtask

   task automatic gate_case(input logic [1:0] gl, rl, tl, cl, input logic f, input logic [15:0] e);
      logic [31:0] ip, sp;
      ip = rnd();
      sp = rnd();
      stg_mem_model_i.put(GBASE + 32'h80, gate(16'h009C, ip, gl));
      stg_mem_model_i.put(LBASE + 32'h98, seg(32'h0, tl, 1'b1));
      stg_mem_model_i.put(TBASE + 32'h8 + 32'(tl) * 8, {16'h0000, ip[15:0], sp});
      run(STG_GATE, {14'h0020, rl}, 32'h0, 32'h0, cl, f, VEC_PROT, e, 32'h0);
      if (!f) begin
         chk(rsp_new_cs, {14'h0027, tl});
         chk(rsp_new_ip, ip);
         chk(rsp_stack_switch, tl < cl);
         if (tl < cl) begin
            chk(rsp_new_ss, ip[15:0]);
            chk(rsp_new_sp, sp);
         end
      end
   endtask

   initial begin
      resetn = 1'b0;
      req_valid = 1'b0;
      req_kind = STG_DATA;
      req_sel = 16'h0000;
      req_offset = 32'h0;
      req_divisor = 32'h0;
      current_priv_level = 2'h0;
      lat = 2'h0;
      fail = 1'b0;
      repeat (12) @(posedge ref_clk);
      #1;
      resetn = 1'b1;
      for (i = 0; i < 16; i++) begin
         r = rnd();
         b = rnd();
         s = {3'h0, r[9:1], 1'b1, r[10], r[12:11]};
         k = r[16] ? STG_STACK : STG_DATA;
         lv = r[14:13];
         stg_mem_model_i.put(slot(s), seg(b, k == STG_STACK ? lv : 2'h3, k == STG_DATA && r[15]));
         o = (i == 0) ? 32'hFFFF_FFFF : rnd();
         run(k, s, o, r, lv, 1'b0, VEC_PROT, 16'h0000, b + o);
         chk(stg_mem_model_i.last_addr_r, slot(s));
      end
      stg_mem_model_i.put(GBASE + 32'h40, seg(32'h1234_5000, 2'h1, 1'b0));
      stg_mem_model_i.put(GBASE + 32'h48, seg(32'h0, 2'h0, 1'b1));
      stg_mem_model_i.put(LBASE, seg(32'h0800_0000, 2'h3, 1'b0));
      run(STG_DATA, 16'h0040, 32'h10, 32'h0, 2'h2, 1'b1, VEC_PROT, 16'h0040, 32'h0);
      run(STG_DATA, 16'h0041, 32'h10, 32'h0, 2'h1, 1'b0, VEC_PROT, 16'h0000, 32'h1234_5010);
      run(STG_DATA, 16'h0042, 32'h10, 32'h0, 2'h0, 1'b1, VEC_PROT, 16'h0040, 32'h0);
      run(STG_STACK, 16'h0040, 32'h4, 32'h0, 2'h1, 1'b0, VEC_PROT, 16'h0000, 32'h1234_5004);
      run(STG_STACK, 16'h0040, 32'h4, 32'h0, 2'h0, 1'b1, VEC_PROT, 16'h0040, 32'h0);
      run(STG_STACK, 16'h0048, 32'h4, 32'h0, 2'h0, 1'b1, VEC_PROT, 16'h0048, 32'h0);
      run(STG_DATA, 16'h0004, 32'h7, 32'h0, 2'h0, 1'b0, VEC_PROT, 16'h0000, 32'h0800_0007);
      run(STG_DATA, 16'h0003, 32'h7, 32'h0, 2'h0, 1'b1, VEC_PROT, 16'h0000, 32'h0);
      fail = 1'b1;
      run(STG_DATA, 16'h0041, 32'h7, 32'h0, 2'h1, 1'b1, VEC_PROT, 16'h0000, 32'h0);
      fail = 1'b0;
      run(STG_DIV, 16'h0041, 32'h0, 32'h0, 2'h0, 1'b1, VEC_DIVIDE, 16'h0000, 32'h0);
      run(STG_DIV, 16'h0041, 32'h0, 32'h1, 2'h0, 1'b0, VEC_DIVIDE, 16'h0000, 32'h0);
      gate_case(2'h3, 2'h0, 2'h2, 2'h2, 1'b0, 16'h0000);
      gate_case(2'h3, 2'h3, 2'h0, 2'h3, 1'b0, 16'h0000);
      gate_case(2'h3, 2'h1, 2'h1, 2'h2, 1'b0, 16'h0000);
      gate_case(2'h1, 2'h0, 2'h2, 2'h1, 1'b1, 16'h009C);
      gate_case(2'h1, 2'h0, 2'h0, 2'h2, 1'b1, 16'h0080);
      gate_case(2'h2, 2'h3, 2'h0, 2'h0, 1'b1, 16'h0080);
      stop_test();
   end

   // Whole run is well under two microseconds; this only cuts a hang
   initial begin
      #50us;
      error_cnt++;
      stop_test();
   end
endmodule // stg_unit_bench
